// File: sha3_accel_consts.vh
// Shared constants for the sponge hash coprocessor.
// Assumes it is included by bare name into each design file that needs it.
`ifndef SHA3_ACCEL_CONSTS_VH
`define SHA3_ACCEL_CONSTS_VH

// State, rate and lane geometry of the 256-bit variant.
`define STATE_W        1600
`define RATE_BITS      1088
`define LANE_W         64
`define NUM_LANES      25
`define RATE_WORDS     17
`define RATE_WORDS_T   5'd17
`define RATE_BYTES     136
`define RATE_BYTES_L   64'd136
`define RATE_LAST_BYTE 135
`define WORD_SHIFT     3
`define LANE_SHIFT     6

// Index of the last permutation round (rounds 0..23).
`define LAST_ROUND     5'd23

// Digest write-back geometry.
`define DIGEST_WORDS   3'd4
`define WB_TAG         5'h1f

// Command function codes.
`define FN_SET_ADDR    7'h00
`define FN_SET_LEN     7'h01

// Padding bytes.
`define PAD_FIRST      8'h06
`define PAD_LAST       8'h80

// Controller state codes, one-hot.
`define ST_IDLE        3'b001
`define ST_RUN         3'b010
`define ST_WB          3'b100

`endif

// File: sponge_round.v
// One round of the 1600-bit permutation, purely combinational.
// Assumes the caller registers the state and steps the round index 0..23.
`timescale 1ns/1ps
`default_nettype none
`include "sha3_accel_consts.vh"

module sponge_round (
    input  wire [`STATE_W-1:0] state_in,
    input  wire [4:0]          round_idx,
    output wire [`STATE_W-1:0] state_out
);

    // Rotation offset of each lane, indexed by x + 5y, lane 0 in the low bits.
    localparam [6*25-1:0] RHO_TAB = {6'd14, 6'd56, 6'd61, 6'd2, 6'd18, 6'd8, 6'd21, 6'd15, 6'd45, 6'd41,
        6'd39, 6'd25, 6'd43, 6'd10, 6'd3, 6'd20, 6'd55, 6'd6, 6'd44, 6'd36, 6'd27, 6'd28, 6'd62, 6'd1, 6'd0};

    // Iota constants, round 0 in the low bits; out-of-range rounds read as zero.
    localparam [64*24-1:0] RC_TAB = {
        64'h8000_0000_8000_8008, 64'h0000_0000_8000_0001, 64'h8000_0000_0000_8080, 64'h8000_0000_8000_8081,
        64'h8000_0000_8000_000a, 64'h0000_0000_0000_800a, 64'h8000_0000_0000_0080, 64'h8000_0000_0000_8002,
        64'h8000_0000_0000_8003, 64'h8000_0000_0000_8089, 64'h8000_0000_0000_008b, 64'h0000_0000_8000_808b,
        64'h0000_0000_8000_000a, 64'h0000_0000_8000_8009, 64'h0000_0000_0000_0088, 64'h0000_0000_0000_008a,
        64'h8000_0000_0000_8009, 64'h8000_0000_8000_8081, 64'h0000_0000_8000_0001, 64'h0000_0000_0000_808b,
        64'h8000_0000_8000_8000, 64'h8000_0000_0000_808a, 64'h0000_0000_0000_8082, 64'h0000_0000_0000_0001};

    function [63:0] round_const;
        input [4:0] r;
        begin
            round_const = (r > `LAST_ROUND) ? 64'h0 : RC_TAB[64*r +: 64];
        end
    endfunction

    wire [`LANE_W*5-1:0]   col_par;
    wire [`LANE_W*5-1:0]   col_mix;
    wire [`STATE_W-1:0]    permuted;
    wire [`STATE_W-1:0]    chi_out;

    genvar x, y;
    generate
        // Theta: column parities and the mixing term for each column.
        for (x = 0; x < 5; x = x + 1) begin : g_theta
            assign col_par[`LANE_W*x +: `LANE_W] = state_in[`LANE_W*x +: `LANE_W]
                ^ state_in[`LANE_W*(x+5) +: `LANE_W] ^ state_in[`LANE_W*(x+10) +: `LANE_W]
                ^ state_in[`LANE_W*(x+15) +: `LANE_W] ^ state_in[`LANE_W*(x+20) +: `LANE_W]; // [R3]
            assign col_mix[`LANE_W*x +: `LANE_W] = col_par[`LANE_W*((x+4)%5) +: `LANE_W]
                ^ {col_par[`LANE_W*((x+1)%5) +: `LANE_W-1], col_par[`LANE_W*((x+1)%5)+`LANE_W-1]}; // [R3]
        end
        // Rho and pi: rotate each mixed lane and move it to its new position.
        for (y = 0; y < 5; y = y + 1) begin : g_rp_y
            for (x = 0; x < 5; x = x + 1) begin : g_rp_x
                localparam integer RO = RHO_TAB[6*(x+5*y) +: 6];
                wire [`LANE_W-1:0] lane = state_in[`LANE_W*(x+5*y) +: `LANE_W] ^ col_mix[`LANE_W*x +: `LANE_W];
                assign permuted[`LANE_W*(y+5*((2*x+3*y)%5)) +: `LANE_W] =
                    (lane << RO) | (lane >> (`LANE_W-RO)); // [R3]
            end
        end
        // Chi: nonlinear row mix; iota then folds the round constant into lane 0.
        for (y = 0; y < 5; y = y + 1) begin : g_chi_y
            for (x = 0; x < 5; x = x + 1) begin : g_chi_x
                assign chi_out[`LANE_W*(x+5*y) +: `LANE_W] = permuted[`LANE_W*(x+5*y) +: `LANE_W]
                    ^ (~permuted[`LANE_W*((x+1)%5+5*y) +: `LANE_W]
                    & permuted[`LANE_W*((x+2)%5+5*y) +: `LANE_W]); // [R3]
            end
        end
    endgenerate

    // Iota touches lane 0 only.
    assign state_out = {chi_out[`STATE_W-1:`LANE_W], chi_out[`LANE_W-1:0] ^ round_const(round_idx)}; // [R3]

endmodule
`default_nettype wire

// File: sha3_coprocessor_accelerator.v
// Sponge hash coprocessor: command intake, block fetcher, permutation control and digest write-back.
// Assumes a tagged 64-bit memory port with its own ready/valid and responses that may come out of order.
`timescale 1ns/1ps
`default_nettype none
`include "sha3_accel_consts.vh"

// Functional notes
// [R1] Only the 256-bit variant: 1600-bit state, 1088-bit message chunks.
// [R2] Each chunk is XORed into the state, then the whole state is permuted.
// [R3] Permutation uses theta, rho, pi, chi and iota with rotations, parities, XORs.
// [R4] Processor sends two 64-bit operands, a return-value flag and a function field.
// [R5] A command passes only when valid and ready are both high.
// [R6] Accepted commands fill a context: source, destination, length and control bits.
// [R7] Fetching starts only once the context is marked valid.
// [R8] Fetcher runs on its own and owns a single one-chunk buffer.
// [R9] One 64-bit word per read, so a chunk takes 17 reads; the final chunk reads only the words below the stored length.
// [R10] Reads go out back to back, tagged with their buffer slot.
// [R11] Full buffer is absorbed, permutation starts, buffer is freed for more reads.
// [R12] After the last chunk is permuted, a write-back machine stores the hash.
// [R13] Digest goes out as four 64-bit stores; no command until they finish.
// [R14] Final chunk gets sponge padding derived from the stored length.
module sha3_coprocessor_accelerator #(
    parameter TAG_W = 5
) (
    input  wire                ref_clk,
    input  wire                reset_n,
    input  wire                cmd_valid,
    output wire                cmd_ready,
    input  wire [6:0]          cmd_funct,
    input  wire [63:0]         cmd_rs1,
    input  wire [63:0]         cmd_rs2,
    input  wire                cmd_xd,
    output wire                busy,
    output wire                mem_req_valid,
    input  wire                mem_req_ready,
    output wire [63:0]         mem_req_addr,
    output wire [TAG_W-1:0]    mem_req_tag,
    output wire                mem_req_write,
    output wire [63:0]         mem_req_data,
    input  wire                mem_resp_valid,
    input  wire [TAG_W-1:0]    mem_resp_tag,
    input  wire [63:0]         mem_resp_data
);

    reg  [2:0]                 fsm_ff;
    reg  [63:0]                src_ff;
    reg  [63:0]                dst_ff;
    reg  [63:0]                len_ff;
    reg                        ctx_valid_ff;
    reg  [`STATE_W-1:0]        state_ff;
    reg  [4:0]                 rnd_ff;
    reg                        perm_busy_ff;
    reg                        last_ff;
    reg  [63:0]                blk_base_ff;
    reg  [4:0]                 issue_idx_ff;
    reg  [`RATE_WORDS-1:0]     slot_ok_ff;
    reg                        fetch_done_ff;
    reg                        req_valid_ff;
    reg  [63:0]                req_addr_ff;
    reg  [TAG_W-1:0]           req_tag_ff;
    reg                        req_write_ff;
    reg  [63:0]                req_data_ff;
    reg  [2:0]                 wb_idx_ff;
    reg  [`LANE_W-1:0]         chunk_mem [0:`RATE_WORDS-1];

    wire [`STATE_W-1:0]        round_out;
    wire [`RATE_BITS-1:0]      blk_bits;
    wire [63:0]                rem;
    wire                       final_blk;
    wire [63:0]                issue_off;
    wire                       word_needed;
    wire                       req_free;
    wire                       fetch_load;
    wire                       buf_full;
    wire                       absorb;
    wire                       perm_end;
    wire                       wb_load;
    wire                       wb_done;
    wire                       cmd_fire;
    wire                       resp_in_rate;

    // The permutation datapath steps one round per clock on the registered state.
    sponge_round u_round (
        .state_in  (state_ff),
        .round_idx (rnd_ff),
        .state_out (round_out)
    );

    // Command side: only taken while idle, so write-back always finishes first.
    assign cmd_ready = (fsm_ff == `ST_IDLE); // [R13]
    assign cmd_fire  = cmd_valid && cmd_ready; // [R5]
    assign busy      = !cmd_ready;

    // Fetch bookkeeping: bytes left from this chunk on, and the offset of the next word.
    assign rem          = len_ff - blk_base_ff;
    assign final_blk    = (rem < `RATE_BYTES_L); // [R14]
    assign issue_off    = blk_base_ff + {56'h0, issue_idx_ff, 3'b000};
    assign word_needed  = (issue_off < len_ff);
    assign req_free     = !req_valid_ff || mem_req_ready;
    assign fetch_load   = (fsm_ff == `ST_RUN) && ctx_valid_ff && !fetch_done_ff
                          && (issue_idx_ff < `RATE_WORDS_T) && req_free; // [R7] [R10]
    assign resp_in_rate = mem_resp_valid && (mem_resp_tag < `RATE_WORDS_T);
    assign buf_full     = &slot_ok_ff; // [R9]
    assign absorb       = (fsm_ff == `ST_RUN) && buf_full && !perm_busy_ff; // [R11]
    assign perm_end     = perm_busy_ff && (rnd_ff == `LAST_ROUND);
    assign wb_load      = (fsm_ff == `ST_WB) && req_free && (wb_idx_ff < `DIGEST_WORDS); // [R13]
    assign wb_done      = (fsm_ff == `ST_WB) && (wb_idx_ff == `DIGEST_WORDS) && !req_valid_ff;

    // Byte view of the chunk: bytes past the end read as zero; the final chunk gets its padding.
    // Masking here means unfetched slots never need clearing, so stale data cannot leak in.
    genvar j;
    generate
        for (j = 0; j < `RATE_BYTES; j = j + 1) begin : g_pad
            localparam [63:0] JB = j;
            wire [7:0] raw  = chunk_mem[j/8][8*(j%8) +: 8];
            wire [7:0] kept = (JB < rem) ? raw : 8'h00;
            wire [7:0] dom  = (final_blk && (JB == rem)) ? `PAD_FIRST : 8'h00;
            wire [7:0] cls  = (final_blk && (j == `RATE_LAST_BYTE)) ? `PAD_LAST : 8'h00;
            assign blk_bits[8*j +: 8] = kept ^ dom ^ cls; // [R14]
        end
    endgenerate

    // Response capture into the single chunk buffer, slot chosen by the tag.
    always @(posedge ref_clk) begin
        if (resp_in_rate) begin
            chunk_mem[mem_resp_tag] <= mem_resp_data; // [R10]
        end
    end

    // Context and controller sequencing.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fsm_ff       <= `ST_IDLE;
            src_ff       <= 64'h0;
            dst_ff       <= 64'h0;
            len_ff       <= 64'h0;
            ctx_valid_ff <= 1'b0;
        end else begin
            case (fsm_ff)
                `ST_IDLE: begin
                    if (cmd_fire && cmd_funct == `FN_SET_ADDR) begin
                        src_ff <= cmd_rs1; // [R6]
                        dst_ff <= cmd_rs2; // [R6]
                    end else if (cmd_fire && cmd_funct == `FN_SET_LEN) begin
                        len_ff       <= cmd_rs1; // [R6]
                        ctx_valid_ff <= 1'b1; // [R6]
                        fsm_ff       <= `ST_RUN;
                    end
                end
                `ST_RUN: begin
                    if (perm_end && last_ff) begin
                        fsm_ff <= `ST_WB; // [R12]
                    end
                end
                `ST_WB: begin
                    if (wb_done) begin
                        ctx_valid_ff <= 1'b0;
                        fsm_ff       <= `ST_IDLE; // [R13]
                    end
                end
                default: fsm_ff <= `ST_IDLE;
            endcase
        end
    end

    // Fetcher: walks the slots and refills once the buffer is absorbed, overlapping the permutation.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            blk_base_ff   <= 64'h0;
            issue_idx_ff  <= 5'h00;
            slot_ok_ff    <= {`RATE_WORDS{1'b0}};
            fetch_done_ff <= 1'b0;
        end else if (cmd_fire && cmd_funct == `FN_SET_LEN) begin
            blk_base_ff   <= 64'h0;
            issue_idx_ff  <= 5'h00;
            slot_ok_ff    <= {`RATE_WORDS{1'b0}};
            fetch_done_ff <= 1'b0;
        end else if (absorb) begin
            blk_base_ff   <= blk_base_ff + `RATE_BYTES_L; // [R11]
            issue_idx_ff  <= 5'h00; // [R11]
            slot_ok_ff    <= {`RATE_WORDS{1'b0}}; // [R8]
            fetch_done_ff <= final_blk;
        end else begin
            if (fetch_load) begin
                issue_idx_ff <= issue_idx_ff + 5'h01; // [R9]
                if (!word_needed) begin
                    slot_ok_ff[issue_idx_ff] <= 1'b1;
                end
            end
            if (resp_in_rate) begin
                slot_ok_ff[mem_resp_tag] <= 1'b1; // [R10]
            end
        end
    end

    // Hash state: cleared on start, XOR-absorbed when the buffer is full, then 24 rounds.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= {`STATE_W{1'b0}};
            rnd_ff       <= 5'h00;
            perm_busy_ff <= 1'b0;
            last_ff      <= 1'b0;
        end else if (cmd_fire && cmd_funct == `FN_SET_LEN) begin
            state_ff     <= {`STATE_W{1'b0}}; // [R1]
            last_ff      <= 1'b0;
        end else if (absorb) begin
            state_ff     <= state_ff ^ {{(`STATE_W-`RATE_BITS){1'b0}}, blk_bits}; // [R1] [R2]
            rnd_ff       <= 5'h00;
            perm_busy_ff <= 1'b1; // [R11]
            last_ff      <= final_blk;
        end else if (perm_busy_ff) begin
            state_ff     <= round_out; // [R2]
            rnd_ff       <= rnd_ff + 5'h01;
            perm_busy_ff <= !perm_end;
        end
    end

    // Request register shared by fetcher and write-back; they never overlap in time.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_valid_ff <= 1'b0;
            req_addr_ff  <= 64'h0;
            req_tag_ff   <= {TAG_W{1'b0}};
            req_write_ff <= 1'b0;
            req_data_ff  <= 64'h0;
            wb_idx_ff    <= 3'h0;
        end else if (fetch_load && word_needed) begin
            req_valid_ff <= 1'b1;
            req_addr_ff  <= src_ff + issue_off; // [R9]
            req_tag_ff   <= issue_idx_ff[TAG_W-1:0]; // [R10]
            req_write_ff <= 1'b0;
            req_data_ff  <= 64'h0;
        end else if (wb_load) begin
            req_valid_ff <= 1'b1;
            req_addr_ff  <= dst_ff + {58'h0, wb_idx_ff, 3'b000}; // [R13]
            req_tag_ff   <= `WB_TAG;
            req_write_ff <= 1'b1; // [R12]
            req_data_ff  <= state_ff[{wb_idx_ff, 6'b00_0000} +: `LANE_W]; // [R13]
            wb_idx_ff    <= wb_idx_ff + 3'h1;
        end else begin
            if (req_free) begin
                req_valid_ff <= 1'b0;
            end
            if (fsm_ff == `ST_IDLE) begin
                wb_idx_ff <= 3'h0;
            end
        end
    end

    assign mem_req_valid = req_valid_ff;
    assign mem_req_addr  = req_addr_ff;
    assign mem_req_tag   = req_tag_ff;
    assign mem_req_write = req_write_ff;
    assign mem_req_data  = req_data_ff;

endmodule
`default_nettype wire

// File: sha3_accel_properties.sv
// Port-level checker for the sponge hash coprocessor.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sha3_accel_properties #(
    parameter TAG_W = 5
) (
    input wire logic             ref_clk,
    input wire logic             reset_n,
    input wire logic             cmd_valid,
    input wire logic             cmd_ready,
    input wire logic [6:0]       cmd_funct,
    input wire logic [63:0]      cmd_rs1,
    input wire logic [63:0]      cmd_rs2,
    input wire logic             busy,
    input wire logic             mem_req_valid,
    input wire logic             mem_req_ready,
    input wire logic [63:0]      mem_req_addr,
    input wire logic [TAG_W-1:0] mem_req_tag,
    input wire logic             mem_req_write,
    input wire logic [63:0]      mem_req_data
);
    logic [63:0] src_ff;
    logic [63:0] dst_ff;
    logic [63:0] len_ff;
    wire         rd = mem_req_valid && !mem_req_write;
    wire         wr_acc = mem_req_valid && mem_req_ready && mem_req_write;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Shadow of the context so addresses can be judged against what software asked for.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_ff <= 64'h0;
            dst_ff <= 64'h0;
            len_ff <= 64'h0;
        end else if (cmd_valid && cmd_ready && cmd_funct == 7'h00) begin
            src_ff <= cmd_rs1;
            dst_ff <= cmd_rs2;
        end else if (cmd_valid && cmd_ready && cmd_funct == 7'h01) begin
            len_ff <= cmd_rs1;
        end
    end
    AST_BUSY_MIRROR: assert property (busy == !cmd_ready) else $error("busy is not the inverse of ready");
    AST_START_HOLDS_OFF: assert property (cmd_valid && cmd_ready && cmd_funct == 7'h01 |=> !cmd_ready [*8])
        else $error("ready came back too early after start");
    AST_NO_FETCH_IDLE: assert property (cmd_ready |-> !mem_req_valid) else $error("request while idle");
    AST_REQ_STABLE: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr)
        && $stable(mem_req_tag) && $stable(mem_req_write) && $stable(mem_req_data)) else $error("request moved");
    AST_READ_SLOT: assert property (rd |-> mem_req_tag < 17 && (mem_req_addr - src_ff) % 136 == mem_req_tag * 8)
        else $error("read tag does not match its slot");
    AST_READ_IN_LEN: assert property (rd |-> mem_req_addr - src_ff < len_ff && mem_req_data == 64'h0)
        else $error("read outside the message");
    AST_WRITE_PLACE: assert property (mem_req_valid && mem_req_write |-> mem_req_tag == 5'h1f
        && mem_req_addr - dst_ff < 32 && mem_req_addr[2:0] == 3'h0) else $error("store outside the digest");
    AST_WRITE_ORDER: assert property (wr_acc && mem_req_addr != dst_ff + 24 |=> mem_req_valid && mem_req_write
        && mem_req_addr == $past(mem_req_addr) + 8) else $error("digest stores out of order");
    AST_DONE_FREES: assert property (wr_acc && mem_req_addr == dst_ff + 24 |=> !cmd_ready ##1 cmd_ready)
        else $error("not idle after last store");
    AST_BUSY_BOUND: assert property ($rose(busy) |-> ##[1:1000] cmd_ready) else $error("hash never finished");
endmodule
bind sha3_coprocessor_accelerator sha3_accel_properties #(.TAG_W(TAG_W)) chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_funct(cmd_funct), .cmd_rs1(cmd_rs1), .cmd_rs2(cmd_rs2), .busy(busy),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
    .mem_req_tag(mem_req_tag), .mem_req_write(mem_req_write), .mem_req_data(mem_req_data));
`default_nettype wire

// File: sha3_mem_model.sv
// Memory model for the coprocessor's tagged port, answering reads in any order.
// Assumes slow is driven by the bench; stores are accepted and not acknowledged.
`timescale 1ns/1ps
`default_nettype none
module sha3_mem_model #(
    parameter TAG_W = 5
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             slow,
    input  wire logic             mem_req_valid,
    input  wire logic [63:0]      mem_req_addr,
    input  wire logic [TAG_W-1:0] mem_req_tag,
    input  wire logic             mem_req_write,
    output logic                  mem_req_ready,
    output logic                  mem_resp_valid,
    output logic [TAG_W-1:0]      mem_resp_tag,
    output logic [63:0]           mem_resp_data
);
    logic [63:0]      pend_addr[$];
    logic [TAG_W-1:0] pend_tag[$];
    int               idx;
    // Content depends on the address so misplaced reads change the digest.
    function automatic logic [7:0] byte_at(input logic [63:0] a);
        return a[7:0] ^ a[15:8] ^ {a[2:0], a[20:16]} ^ 8'h5a;
    endfunction
    function automatic logic [63:0] word_at(input logic [63:0] a);
        logic [63:0] w;
        for (int i = 0; i < 8; i++) w[8*i+:8] = byte_at(a + i);
        return w;
    endfunction
    // Idle response lines toggle so a stale word is never mistaken for a fresh one.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_req_ready <= 1'b0;
            mem_resp_valid <= 1'b0;
            mem_resp_tag <= '0;
            mem_resp_data <= 64'h0;
            pend_addr.delete();
            pend_tag.delete();
        end else begin
            if (mem_req_valid && mem_req_ready && !mem_req_write) begin
                pend_addr.push_back(mem_req_addr);
                pend_tag.push_back(mem_req_tag);
            end
            mem_req_ready <= slow ? ($urandom % 3 == 0) : 1'b1;
            mem_resp_valid <= 1'b0;
            mem_resp_tag <= ~mem_resp_tag;
            mem_resp_data <= ~mem_resp_data;
            if (pend_addr.size() > 0 && (!slow || $urandom % 4 == 0)) begin
                idx = $urandom % pend_addr.size();
                mem_resp_valid <= 1'b1;
                mem_resp_tag <= pend_tag[idx];
                mem_resp_data <= word_at(pend_addr[idx]);
                pend_addr.delete(idx);
                pend_tag.delete(idx);
            end
        end
    end
endmodule
`default_nettype wire

// File: test_sha3_coprocessor_accelerator.sv
// Bench: hashes corner and random message lengths and checks the stored digest.
// Assumes the memory model supplies the message and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module test_sha3_coprocessor_accelerator;
    logic ref_clk = 0, reset_n = 0, cmd_valid = 0, cmd_xd = 0, slow = 0;
    logic [6:0] cmd_funct = 7'h00;
    logic [63:0] cmd_rs1 = 64'h0, cmd_rs2 = 64'h0, hash_dst = 64'h0, off;
    logic [63:0] st[25], got[4];
    wire cmd_ready, busy, mem_req_valid, mem_req_ready, mem_req_write, mem_resp_valid;
    wire [63:0] mem_req_addr, mem_req_data, mem_resp_data;
    wire [4:0] mem_req_tag, mem_resp_tag;
    int err_count = 0, n_tests = 0, cycles = 0, rotoff[25];
    int lens[8] = '{0, 1, 8, 135, 136, 137, 271, 272};
    always #4 ref_clk = ~ref_clk;
    sha3_coprocessor_accelerator #(.TAG_W(5)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_funct(cmd_funct), .cmd_rs1(cmd_rs1), .cmd_rs2(cmd_rs2), .cmd_xd(cmd_xd),
        .busy(busy), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
        .mem_req_tag(mem_req_tag), .mem_req_write(mem_req_write), .mem_req_data(mem_req_data),
        .mem_resp_valid(mem_resp_valid), .mem_resp_tag(mem_resp_tag), .mem_resp_data(mem_resp_data));
    sha3_mem_model #(.TAG_W(5)) mem (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
        .mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr), .mem_req_tag(mem_req_tag),
        .mem_req_write(mem_req_write), .mem_req_ready(mem_req_ready), .mem_resp_valid(mem_resp_valid),
        .mem_resp_tag(mem_resp_tag), .mem_resp_data(mem_resp_data));
    // Watchdog and digest capture; a hang ends the run rather than stalling it.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            stop_test();
        end
        off = mem_req_addr - hash_dst;
        if (mem_req_valid && mem_req_ready && mem_req_write && off < 32) got[off[4:3]] = mem_req_data;
    end
    function automatic logic [63:0] rotl(input logic [63:0] v, input int n);
        return (v << n) | (v >> ((64 - n) % 64));
    endfunction
    // Reference permutation: theta, rho and pi, chi, then iota with the constant from the LFSR.
    task automatic permute();
        logic [63:0] c[5], b[25], rc;
        logic [7:0] lf;
        lf = 8'h01;
        for (int r = 0; r < 24; r++) begin
            for (int x = 0; x < 5; x++) c[x] = st[x] ^ st[x+5] ^ st[x+10] ^ st[x+15] ^ st[x+20];
            for (int x = 0; x < 25; x++) st[x] ^= c[(x + 4) % 5] ^ rotl(c[(x + 1) % 5], 1);
            for (int x = 0; x < 5; x++)
                for (int y = 0; y < 5; y++) b[y + 5 * ((2 * x + 3 * y) % 5)] = rotl(st[x + 5 * y], rotoff[x + 5 * y]);
            for (int x = 0; x < 25; x++) st[x] = b[x] ^ (~b[(x % 5 + 1) % 5 + x / 5 * 5] & b[(x % 5 + 2) % 5 + x / 5 * 5]);
            rc = 64'h0;
            for (int j = 0; j < 7; j++) begin
                rc[(1 << j) - 1] = lf[0];
                lf = {lf[6:0], 1'b0} ^ (lf[7] ? 8'h71 : 8'h00);
            end
            st[0] ^= rc;
        end
    endtask
    // Expected digest: absorb padded chunks by XOR, permuting after each one.
    task automatic expect_hash(input logic [63:0] src, input int len);
        logic [7:0] blk[136];
        int n;
        for (int i = 0; i < 25; i++) st[i] = 64'h0;
        n = len / 136 + 1;
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 136; i++) blk[i] = (k * 136 + i < len) ? mem.byte_at(src + k * 136 + i) : 8'h00;
            if (k == n - 1) begin
                blk[len % 136] ^= 8'h06;
                blk[135] ^= 8'h80;
            end
            for (int i = 0; i < 136; i++) st[i / 8][8 * (i % 8)+:8] ^= blk[i];
            permute();
        end
    endtask
    task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] seen);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic seen);
        check_word(what, {63'h0, exp}, {63'h0, seen});
    endtask
    // Offers a command at the falling edge and holds it until ready is high at a rising edge.
    task automatic send_cmd(input logic [6:0] f, input logic [63:0] a, input logic [63:0] b);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_funct = f;
        cmd_rs1 = a;
        cmd_rs2 = b;
        cmd_xd = $urandom;
        for (int k = 0; cmd_ready !== 1'b1 && k < 3000; k++) @(negedge ref_clk);
        @(posedge ref_clk);
    endtask
    // One hash: unknown code, addresses, start back to back, then a command held off while busy.
    task automatic run_hash(input int len, input logic slow_mem);
        logic [63:0] src;
        src = {$urandom, $urandom} & 64'h0000_00ff_ffff_fff8;
        hash_dst = {$urandom, $urandom} & 64'h0000_00ff_ffff_ffe0;
        for (int i = 0; i < 4; i++) got[i] = 'x;
        slow = slow_mem;
        send_cmd(7'h05, {$urandom, $urandom}, {$urandom, $urandom});
        send_cmd(7'h00, src, hash_dst);
        send_cmd(7'h01, len, {$urandom, $urandom});
        @(negedge ref_clk);
        check_bit("cmd_ready after start", 1'b0, cmd_ready);
        send_cmd(7'h00, {$urandom, $urandom}, {$urandom, $urandom});
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        expect_hash(src, len);
        for (int i = 0; i < 4; i++) check_word("digest word", st[i], got[i]);
        $display("test len %0d slow %0d finished", len, slow_mem);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Corner lengths around the chunk size, alternating fast and slow memory, then random lengths.
    initial begin
        int x, y, t, s;
        s = $urandom(32'h69bd);
        x = 1;
        y = 0;
        rotoff[0] = 0;
        for (t = 0; t < 24; t++) begin
            rotoff[x + 5 * y] = ((t + 1) * (t + 2) / 2) % 64;
            s = y;
            y = (2 * x + 3 * y) % 5;
            x = s;
        end
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) run_hash(lens[i], i[0]);
        for (int i = 0; i < 6; i++) run_hash($urandom % 280, $urandom % 2);
        stop_test();
    end
endmodule
`default_nettype wire
